// *** aicr_pkg.sv ***
// Purpose: shared constants for the converter interrupt and misc control bank
// Assumes: 8-bit registers on a 12-bit register address
// Notes:   writable masks define which bits store; all other bits read zero
`default_nettype none
package aicr_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SLACK_W = 10;

	localparam logic [11:0] OFF_IRQ_STATUS = 12'h100;
	localparam logic [11:0] OFF_IRQ_MASK   = 12'h101;
	localparam logic [11:0] OFF_DIG_FIXED  = 12'h105;
	localparam logic [11:0] OFF_CAL_EN     = 12'h10A;
	localparam logic [11:0] OFF_CAL_THR_A  = 12'h10D;
	localparam logic [11:0] OFF_CAL_THR_B  = 12'h10E;
	localparam logic [11:0] OFF_QCLK_CTRL  = 12'h120;
	localparam logic [11:0] OFF_TRIM_SEL   = 12'h121;
	localparam logic [11:0] OFF_RSVD_KEEP  = 12'h12A;
	localparam logic [11:0] OFF_DDC0_GAIN  = 12'h130;

	localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK   = 8'hBC;
	localparam logic [7:0] RST_DIG_FIXED  = 8'h00;
	localparam logic [7:0] RST_CAL_EN     = 8'h10;
	localparam logic [7:0] RST_CAL_THR_A  = 8'h3D;
	localparam logic [7:0] RST_CAL_THR_B  = 8'h14;
	localparam logic [7:0] RST_QCLK_CTRL  = 8'h11;
	localparam logic [1:0] RST_TRIM_SEL   = 2'h0;
	localparam logic [7:0] RST_RSVD_KEEP  = 8'h05;
	localparam logic [7:0] RST_DDC0_GAIN  = 8'h00;

	localparam logic [7:0] WM_IRQ_MASK  = 8'hBD;
	localparam logic [7:0] WM_DIG_FIXED = 8'h1F;
	localparam logic [7:0] WM_CAL_EN    = 8'h10;
	localparam logic [7:0] WM_QCLK_CTRL = 8'h1B;
	localparam logic [7:0] WM_TRIM_SEL  = 8'h03;
	localparam logic [7:0] WM_DDC0_GAIN = 8'h33;

	localparam int BIT_PLL_UNLOCK = 7;
	localparam int BIT_SR_HOLD    = 3;
	localparam int BIT_SR_SETUP   = 2;
	localparam int BIT_CLK_ERR    = 0;
	localparam int BIT_CAL_EN     = 4;
	localparam int BIT_QCLK_EN    = 4;
	localparam int BIT_QCLK_TERM  = 3;
	localparam int LSB_QCLK_SWING = 0;
	localparam int LSB_GAIN_D2    = 4;
	localparam int LSB_GAIN_D8    = 0;

	localparam logic [9:0] GUARD_STEP_PS = 10'h023;
	localparam logic [1:0] QDIV_HALF_TICKS = 2'h2;
endpackage
`default_nettype wire

// *** aicr_quarter_div.sv ***
// Purpose: divide the sample-rate tick stream by four for the divided clock pin
// Assumes: sample_tick is a one-cycle enable on the register clock
// Notes:   output held low while disabled; restarts in phase on enable
`default_nettype none
module aicr_quarter_div (
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic sample_tick,
	input  wire logic enable,
	output var  logic clk_out
);
	logic [1:0] ticks;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ticks <= 2'h0;
			clk_out <= 1'b0;
		end else if (!enable) begin
			ticks <= 2'h0;
			clk_out <= 1'b0;
		end else if (sample_tick) begin
			// two ticks per half period gives a quarter-rate square wave
			if (ticks == aicr_pkg::QDIV_HALF_TICKS - 2'h1) begin
				ticks <= 2'h0;
				clk_out <= ~clk_out; // RULE_12
			end else begin
				ticks <= ticks + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** aicr_regs.sv ***
// Purpose: interrupt status/mask and misc control register bank of the converter
// Assumes: single register clock; pll_unlocked and clock_error come from other domains
// Notes:   read data stands only in the cycle after the read strobe
//
// Function
// RULE_01 - status bit 7 reads one while the PLL is out of lock
// RULE_02 - status bit 3 latches a SYSREF hold violation until cleared
// RULE_03 - status bit 2 latches a SYSREF setup violation until cleared
// RULE_04 - setting then clearing 0x03A bit 6 clears both SYSREF flags
// RULE_05 - status bit 0 is a read-only clock error indication
// RULE_06 - mask bit 7 keeps PLL unlock from raising the interrupt
// RULE_07 - mask bit 0 gates clock error; only device reset recovers
// RULE_08 - mask resets to 0xBC; host writes ones to bits 5 and 4
// RULE_09 - host writes zero to digital control bits 4..0; resets to zero
// RULE_10 - calibration threshold control bit 4 enables threshold logic, reset 0x10
// RULE_11 - two 8-bit threshold registers reset to 0x3D and 0x14
// RULE_12 - divided clock output runs at a quarter of the sample rate
// RULE_13 - divided clock control bit 4 enables the output, reset 0x11
// RULE_14 - bit 3 selects termination, bits 1..0 pick swing in 100 mV steps
// RULE_15 - 2-bit trim select; reset value follows the speed grade
// RULE_16 - host leaves reserved register 0x12A at 0x05
// RULE_17 - gain bits 5..4 set decimate-by-2 gain in 6 dB steps
// RULE_18 - gain bits 1..0 set decimate-by-8 gain in 6 dB steps
// RULE_19 - interrupt status is read-only and resets to 0x00
// RULE_20 - guardband codes add 35 ps per step to flag windows only
// RULE_21 - interrupt request is high while any unmasked flag is set
// RULE_22 - writes to unused or read-only bits do nothing; they read zero
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module aicr_regs #(
	parameter logic [1:0] TRIM_RESET = aicr_pkg::RST_TRIM_SEL
) (
	input  wire logic                       clock,
	input  wire logic                       arst_n,
	input  wire logic [aicr_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [aicr_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output var  logic [aicr_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                       pll_unlocked,
	input  wire logic                       clock_error,
	input  wire logic                       sysref_flag_clear,
	input  wire logic                       sysref_seen,
	input  wire logic                       setup_violation,
	input  wire logic                       hold_violation,
	input  wire logic [aicr_pkg::SLACK_W-1:0] setup_slack_ps,
	input  wire logic [aicr_pkg::SLACK_W-1:0] hold_slack_ps,
	input  wire logic [2:0]                 setup_guard_code,
	input  wire logic [2:0]                 hold_guard_code,
	input  wire logic                       sample_tick,
	output logic                            irq_out,
	output logic                            quarter_rate_clock_out,
	output logic                            quarter_clock_no_term,
	output logic [1:0]                      quarter_clock_swing,
	output logic                            cal_threshold_enable,
	output logic [7:0]                      cal_threshold_a,
	output logic [7:0]                      cal_threshold_b,
	output logic [1:0]                      rate_trim,
	output logic [1:0]                      first_downconverter_gain_d2,
	output logic [1:0]                      first_downconverter_gain_d8,
	output logic [4:0]                      digital_control_bits,
	output logic [7:0]                      reserved_keep_value
);

	// register storage
	logic [7:0] interrupt_mask;
	logic [7:0] digital_control_fixed;
	logic [7:0] gain_cal_threshold_enable;
	logic [7:0] gain_cal_threshold_a;
	logic [7:0] gain_cal_threshold_b;
	logic [7:0] quarter_clock_output_ctrl;
	logic [7:0] rate_trim_select;
	logic [7:0] reserved_keep_default;
	logic [7:0] downconverter0_gain;

	// status state
	logic       setup_flag;
	logic       hold_flag;
	logic       clk_err_flag;
	logic [7:0] interrupt_status;

	// pin synchronisers: three stages, change taken when stages two and three agree
	logic [2:0] pll_sync;
	logic [2:0] clk_sync;
	logic       pll_level;
	logic       clk_level;

	logic       clear_prev;
	logic       clear_pulse;
	logic       setup_bad;
	logic       hold_bad;
	logic [7:0] next_rdata;

	function automatic logic hit(input logic [aicr_pkg::ADDR_W-1:0] a,
			input logic [aicr_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] wmask);
		merge = (old & ~wmask) | (wd & wmask);
	endfunction

	// guardband widens the flagging window, never the real capture timing
	function automatic logic [aicr_pkg::SLACK_W-1:0] guard_ps(input logic [2:0] code);
		guard_ps = aicr_pkg::GUARD_STEP_PS * {7'h00, code};
	endfunction

	// a status bit raises the request only while its mask bit is clear
	function automatic logic pending(input logic [7:0] st, input logic [7:0] mk,
			input int b);
		pending = st[b] & ~mk[b];
	endfunction

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pll_sync <= 3'h0;
		end else begin
			pll_sync <= {pll_sync[1:0], pll_unlocked};
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clk_sync <= 3'h0;
		end else begin
			clk_sync <= {clk_sync[1:0], clock_error};
		end
	end

	// a pin glitch shorter than one clock never reaches the status bits
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pll_level <= 1'b0;
		end else if (pll_sync[1] == pll_sync[2]) begin
			pll_level <= pll_sync[2];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clk_level <= 1'b0;
		end else if (clk_sync[1] == clk_sync[2]) begin
			clk_level <= clk_sync[2];
		end
	end

	// clear sequence: the falling edge of the clear control ends set-then-clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clear_prev <= 1'b0;
		end else begin
			clear_prev <= sysref_flag_clear;
		end
	end

	assign clear_pulse = clear_prev & ~sysref_flag_clear; // RULE_04

	assign setup_bad = setup_violation | (setup_slack_ps < guard_ps(setup_guard_code)); // RULE_20
	assign hold_bad = hold_violation | (hold_slack_ps < guard_ps(hold_guard_code)); // RULE_20

	// a violation in the same cycle as the clear wins, so no event is lost
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			setup_flag <= 1'b0;
		end else if (sysref_seen && setup_bad) begin
			setup_flag <= 1'b1; // RULE_03
		end else if (clear_pulse) begin
			setup_flag <= 1'b0; // RULE_04
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hold_flag <= 1'b0;
		end else if (sysref_seen && hold_bad) begin
			hold_flag <= 1'b1; // RULE_02
		end else if (clear_pulse) begin
			hold_flag <= 1'b0; // RULE_04
		end
	end

	// clock error has no software clear: recovery is a device reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clk_err_flag <= 1'b0;
		end else if (clk_level) begin
			clk_err_flag <= 1'b1; // RULE_07
		end
	end

	// unused status positions stay at their reset zero
	always_comb begin
		interrupt_status = aicr_pkg::RST_IRQ_STATUS; // RULE_19
		interrupt_status[aicr_pkg::BIT_PLL_UNLOCK] = pll_level; // RULE_01
		interrupt_status[aicr_pkg::BIT_SR_HOLD] = hold_flag;
		interrupt_status[aicr_pkg::BIT_SR_SETUP] = setup_flag;
		interrupt_status[aicr_pkg::BIT_CLK_ERR] = clk_err_flag; // RULE_05
	end

	// mask bits 5 and 4 store but never gate anything
	always_comb begin
		irq_out = 1'b0;
		if (pending(interrupt_status, interrupt_mask, aicr_pkg::BIT_PLL_UNLOCK)) begin
			irq_out = 1'b1; // RULE_06
		end
		if (pending(interrupt_status, interrupt_mask, aicr_pkg::BIT_SR_HOLD)) begin
			irq_out = 1'b1; // RULE_21
		end
		if (pending(interrupt_status, interrupt_mask, aicr_pkg::BIT_SR_SETUP)) begin
			irq_out = 1'b1; // RULE_21
		end
		if (pending(interrupt_status, interrupt_mask, aicr_pkg::BIT_CLK_ERR)) begin
			irq_out = 1'b1; // RULE_07
		end
	end

	// register writes; only writable bits store
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			interrupt_mask <= aicr_pkg::RST_IRQ_MASK; // RULE_08
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_IRQ_MASK)) begin
			interrupt_mask <= merge(interrupt_mask, reg_wdata, aicr_pkg::WM_IRQ_MASK); // RULE_22
		end
	end

	// stored as written: the zero value is the host's duty
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			digital_control_fixed <= aicr_pkg::RST_DIG_FIXED;
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_DIG_FIXED)) begin
			digital_control_fixed <= merge(digital_control_fixed, reg_wdata, aicr_pkg::WM_DIG_FIXED); // RULE_09
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gain_cal_threshold_enable <= aicr_pkg::RST_CAL_EN; // RULE_10
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_CAL_EN)) begin
			gain_cal_threshold_enable <= merge(gain_cal_threshold_enable, reg_wdata, aicr_pkg::WM_CAL_EN);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gain_cal_threshold_a <= aicr_pkg::RST_CAL_THR_A; // RULE_11
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_CAL_THR_A)) begin
			gain_cal_threshold_a <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gain_cal_threshold_b <= aicr_pkg::RST_CAL_THR_B; // RULE_11
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_CAL_THR_B)) begin
			gain_cal_threshold_b <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			quarter_clock_output_ctrl <= aicr_pkg::RST_QCLK_CTRL; // RULE_13
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_QCLK_CTRL)) begin
			quarter_clock_output_ctrl <= merge(quarter_clock_output_ctrl, reg_wdata, aicr_pkg::WM_QCLK_CTRL);
		end
	end

	// speed grade chooses the trim reset through the parameter
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rate_trim_select <= {6'h00, TRIM_RESET}; // RULE_15
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_TRIM_SEL)) begin
			rate_trim_select <= merge(rate_trim_select, reg_wdata, aicr_pkg::WM_TRIM_SEL);
		end
	end

	// kept writable; leaving it at its default is up to the host
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reserved_keep_default <= aicr_pkg::RST_RSVD_KEEP;
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_RSVD_KEEP)) begin
			reserved_keep_default <= reg_wdata; // RULE_16
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			downconverter0_gain <= aicr_pkg::RST_DDC0_GAIN;
		end else if (reg_wr && hit(reg_addr, aicr_pkg::OFF_DDC0_GAIN)) begin
			downconverter0_gain <= merge(downconverter0_gain, reg_wdata, aicr_pkg::WM_DDC0_GAIN);
		end
	end

	// read mux; unmapped addresses answer zero, status writes are ignored
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			aicr_pkg::OFF_IRQ_STATUS: next_rdata = interrupt_status; // RULE_19
			aicr_pkg::OFF_IRQ_MASK:   next_rdata = interrupt_mask;
			aicr_pkg::OFF_DIG_FIXED:  next_rdata = digital_control_fixed;
			aicr_pkg::OFF_CAL_EN:     next_rdata = gain_cal_threshold_enable;
			aicr_pkg::OFF_CAL_THR_A:  next_rdata = gain_cal_threshold_a;
			aicr_pkg::OFF_CAL_THR_B:  next_rdata = gain_cal_threshold_b;
			aicr_pkg::OFF_QCLK_CTRL:  next_rdata = quarter_clock_output_ctrl;
			aicr_pkg::OFF_TRIM_SEL:   next_rdata = rate_trim_select;
			aicr_pkg::OFF_RSVD_KEEP:  next_rdata = reserved_keep_default;
			aicr_pkg::OFF_DDC0_GAIN:  next_rdata = downconverter0_gain;
			default:                  next_rdata = 8'h00; // RULE_22
		endcase
	end

	// zero outside the answer cycle, so a stale value never looks like a read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// phase restarts on every enable, so the first half period after enable is a full two ticks
	aicr_quarter_div u_qdiv (
		.clock       (clock),
		.arst_n      (arst_n),
		.sample_tick (sample_tick),
		.enable      (quarter_clock_output_ctrl[aicr_pkg::BIT_QCLK_EN]), // RULE_13
		.clk_out     (quarter_rate_clock_out)
	);

	assign quarter_clock_no_term = quarter_clock_output_ctrl[aicr_pkg::BIT_QCLK_TERM]; // RULE_14
	assign quarter_clock_swing = quarter_clock_output_ctrl[aicr_pkg::LSB_QCLK_SWING +: 2]; // RULE_14
	assign cal_threshold_enable = gain_cal_threshold_enable[aicr_pkg::BIT_CAL_EN]; // RULE_10
	assign cal_threshold_a = gain_cal_threshold_a;
	assign cal_threshold_b = gain_cal_threshold_b;
	assign rate_trim = rate_trim_select[1:0]; // RULE_15
	assign first_downconverter_gain_d2 = downconverter0_gain[aicr_pkg::LSB_GAIN_D2 +: 2]; // RULE_17
	assign first_downconverter_gain_d8 = downconverter0_gain[aicr_pkg::LSB_GAIN_D8 +: 2]; // RULE_18
	assign digital_control_bits = digital_control_fixed[4:0];
	assign reserved_keep_value = reserved_keep_default;

endmodule
`default_nettype wire

// *** aicr_checker.sv ***
// Purpose: port-level timing checks on the converter control bank
// Assumes: one clock domain, async active-low reset
// Notes:   status and mask are internal, so interrupt relations are judged by the bench
`default_nettype none
module aicr_checker (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        sample_tick,
	input wire logic        quarter_rate_clock_out,
	input wire logic        quarter_clock_no_term,
	input wire logic [1:0]  quarter_clock_swing,
	input wire logic        cal_threshold_enable,
	input wire logic [7:0]  cal_threshold_a,
	input wire logic [1:0]  rate_trim,
	input wire logic [1:0]  first_downconverter_gain_d2,
	input wire logic [1:0]  first_downconverter_gain_d8
);
	timeunit 1ns;
	timeprecision 1ps;
	logic w_cal;
	logic w_thr;
	logic w_qclk;
	logic w_trim;
	logic w_gain;
	assign w_cal = reg_wr && (reg_addr == aicr_pkg::OFF_CAL_EN);
	assign w_thr = reg_wr && (reg_addr == aicr_pkg::OFF_CAL_THR_A);
	assign w_qclk = reg_wr && (reg_addr == aicr_pkg::OFF_QCLK_CTRL);
	assign w_trim = reg_wr && (reg_addr == aicr_pkg::OFF_TRIM_SEL);
	assign w_gain = reg_wr && (reg_addr == aicr_pkg::OFF_DDC0_GAIN);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read cycle");
	a_thr_write: assert property (w_thr |=> cal_threshold_a == $past(reg_wdata))
		else $error("threshold a not loaded");
	a_thr_hold: assert property (!w_thr |=> $stable(cal_threshold_a))
		else $error("threshold a changed without write");
	a_cal_write: assert property (w_cal |=> cal_threshold_enable == $past(reg_wdata[4]))
		else $error("calibration enable not loaded");
	a_qclk_fields: assert property (w_qclk |=>
		{quarter_clock_no_term, quarter_clock_swing} == {$past(reg_wdata[3]), $past(reg_wdata[1:0])})
		else $error("divided clock fields not loaded");
	a_trim_write: assert property (w_trim |=> rate_trim == $past(reg_wdata[1:0]))
		else $error("trim select not loaded");
	a_gain_write: assert property (w_gain |=>
		{first_downconverter_gain_d2, first_downconverter_gain_d8} == {$past(reg_wdata[5:4]), $past(reg_wdata[1:0])})
		else $error("gain fields not loaded");
	a_qclk_tick: assert property ($changed(quarter_rate_clock_out) && !$past(w_qclk) |-> $past(sample_tick))
		else $error("divided clock moved without a sample tick");
	c_read_data: cover property (reg_rd ##1 reg_rdata != 8'h00);
	c_qclk_rise: cover property ($rose(quarter_rate_clock_out));
	c_gain_write: cover property (w_gain);
endmodule
`default_nettype wire

// *** aicr_host_model.sv ***
// Purpose: host controller model driving the register port and the flag clear line
// Assumes: strobes change by non-blocking assignment just after a rising edge
// Notes:   released address and data show the inverse of the last value, never a stale copy
`default_nettype none
module aicr_host_model (
	input  wire logic        clock,
	input  wire logic [7:0]  reg_rdata,
	output var  logic [11:0] reg_addr,
	output var  logic [7:0]  reg_wdata,
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	output var  logic        sysref_flag_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sysref_flag_clear = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 12'h101) v[5:4] = 2'h3;
		if (a == 12'h105) v[4:0] = 5'h00;
		if (a == 12'h12A) v = 8'h05;
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
		// step past the edge so callers see the updated registers
		#1;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
	// set then clear, as the flag register outside this block would do
	task automatic clear_flags();
		@(posedge clock);
		sysref_flag_clear <= 1'b1;
		@(posedge clock);
		sysref_flag_clear <= 1'b0;
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

// *** aicr_tb.sv ***
// Purpose: self-checking bench for the converter control bank
// Assumes: sample tick runs at the register clock rate during the divider test
// Notes:   trim reset is set to the slower grade so the parameter path is exercised
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic pll_unlocked = 1'b0;
	logic clock_error = 1'b0;
	logic sysref_seen = 1'b0;
	logic setup_violation = 1'b0;
	logic hold_violation = 1'b0;
	logic [9:0] setup_slack_ps = 10'h3FF;
	logic [9:0] hold_slack_ps = 10'h3FF;
	logic [2:0] setup_guard_code = 3'h3;
	logic [2:0] hold_guard_code = 3'h0;
	logic sample_tick = 1'b0;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, cal_threshold_a, cal_threshold_b, reserved_keep_value;
	logic reg_wr, reg_rd, sysref_flag_clear, irq_out, quarter_rate_clock_out, quarter_clock_no_term;
	logic cal_threshold_enable;
	logic [1:0] quarter_clock_swing, rate_trim, first_downconverter_gain_d2, first_downconverter_gain_d8;
	logic [4:0] digital_control_bits;
	int n_mismatch = 0;
	int check_count = 0;
	logic [11:0] ra [0:10] = '{12'h100, 12'h101, 12'h105, 12'h10A, 12'h10D, 12'h10E, 12'h120, 12'h121, 12'h12A,
		12'h130, 12'h0FF};
	logic [7:0] rv [0:10] = '{8'h00, 8'hBC, 8'h00, 8'h10, 8'h3D, 8'h14, 8'h11, 8'h03, 8'h05, 8'h00, 8'h00};
	logic [11:0] wa [0:7] = '{12'h100, 12'h101, 12'h10A, 12'h10D, 12'h10E, 12'h120, 12'h121, 12'h0FF};
	logic [7:0] wd [0:7] = '{8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hFE, 8'hFF};
	logic [7:0] we [0:7] = '{8'h00, 8'hBD, 8'h10, 8'hA5, 8'h5A, 8'h1B, 8'h02, 8'h00};
	always #10 clock = ~clock;
	aicr_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .sysref_flag_clear(sysref_flag_clear));
	aicr_regs #(.TRIM_RESET(2'h3)) dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pll_unlocked(pll_unlocked), .clock_error(clock_error), .sysref_flag_clear(sysref_flag_clear),
		.sysref_seen(sysref_seen), .setup_violation(setup_violation), .hold_violation(hold_violation),
		.setup_slack_ps(setup_slack_ps), .hold_slack_ps(hold_slack_ps), .setup_guard_code(setup_guard_code),
		.hold_guard_code(hold_guard_code), .sample_tick(sample_tick), .irq_out(irq_out),
		.quarter_rate_clock_out(quarter_rate_clock_out), .quarter_clock_no_term(quarter_clock_no_term),
		.quarter_clock_swing(quarter_clock_swing), .cal_threshold_enable(cal_threshold_enable),
		.cal_threshold_a(cal_threshold_a), .cal_threshold_b(cal_threshold_b), .rate_trim(rate_trim),
		.first_downconverter_gain_d2(first_downconverter_gain_d2),
		.first_downconverter_gain_d8(first_downconverter_gain_d8),
		.digital_control_bits(digital_control_bits), .reserved_keep_value(reserved_keep_value));
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		cmp(d, e);
	endtask
	task automatic sref(input logic h, input logic [9:0] sl);
		@(posedge clock);
		sysref_seen <= 1'b1;
		hold_violation <= h;
		setup_slack_ps <= sl;
		@(posedge clock);
		sysref_seen <= 1'b0;
		hold_violation <= 1'b0;
		setup_slack_ps <= 10'h3FF;
		repeat (2) @(posedge clock);
	endtask
	task automatic toggles(output logic [7:0] n);
		logic p;
		n = 8'h00;
		@(posedge clock);
		#1 p = quarter_rate_clock_out;
		repeat (16) begin
			@(posedge clock);
			#1 if (quarter_rate_clock_out !== p) n++;
			p = quarter_rate_clock_out;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		logic [7:0] n;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		cmp({7'h00, irq_out}, 8'h00);
		for (int i = 0; i < 11; i++) chk(ra[i], rv[i]);
		for (int i = 0; i < 8; i++) begin
			host.wr(wa[i], wd[i]);
			chk(wa[i], we[i]);
		end
		host.wr(12'h105, 8'hFF);
		host.wr(12'h12A, 8'hFF);
		cmp(cal_threshold_b, 8'h5A);
		cmp(reserved_keep_value, 8'h05);
		cmp({quarter_clock_no_term, cal_threshold_enable, 1'b0, digital_control_bits}, 8'hC0);
		for (int i = 0; i < 4; i++) begin
			host.wr(12'h130, {2'h0, i[1:0], 2'h0, i[1:0]});
			host.wr(12'h120, {6'h04, i[1:0]});
			host.wr(12'h121, {6'h00, i[1:0]});
			cmp({first_downconverter_gain_d2, first_downconverter_gain_d8, quarter_clock_swing, rate_trim},
				{4{i[1:0]}});
		end
		sref(1'b1, 10'h3FF);
		chk(12'h100, 8'h08);
		cmp({7'h00, irq_out}, 8'h00);
		host.wr(12'h101, 8'h30);
		cmp({7'h00, irq_out}, 8'h01);
		host.clear_flags();
		chk(12'h100, 8'h00);
		sref(1'b0, 10'd105);
		chk(12'h100, 8'h00);
		sref(1'b0, 10'd104);
		chk(12'h100, 8'h04);
		host.clear_flags();
		pll_unlocked <= 1'b1;
		repeat (6) @(posedge clock);
		chk(12'h100, 8'h80);
		cmp({7'h00, irq_out}, 8'h01);
		host.wr(12'h101, 8'hB0);
		cmp({7'h00, irq_out}, 8'h00);
		pll_unlocked <= 1'b0;
		clock_error <= 1'b1;
		repeat (6) @(posedge clock);
		clock_error <= 1'b0;
		repeat (6) @(posedge clock);
		chk(12'h100, 8'h01);
		cmp({7'h00, irq_out}, 8'h01);
		host.wr(12'h101, 8'hB1);
		cmp({7'h00, irq_out}, 8'h00);
		sample_tick <= 1'b1;
		toggles(n);
		cmp(n, 8'h08);
		host.wr(12'h120, 8'h01);
		toggles(n);
		cmp({n[6:0], quarter_rate_clock_out}, 8'h00);
		end_of_test();
	end
endmodule
bind aicr_regs aicr_checker chk_i (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
	.quarter_rate_clock_out(quarter_rate_clock_out), .quarter_clock_no_term(quarter_clock_no_term),
	.quarter_clock_swing(quarter_clock_swing), .cal_threshold_enable(cal_threshold_enable),
	.cal_threshold_a(cal_threshold_a), .rate_trim(rate_trim),
	.first_downconverter_gain_d2(first_downconverter_gain_d2),
	.first_downconverter_gain_d8(first_downconverter_gain_d8));
`default_nettype wire
